// ---- adcf_analog_model.sv ----
`timescale 1ns/1ns
module adcf_analog_model #(
	parameter int RW = 12
) (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_start,
	input wire logic [RW-1:0] i_value,
	input wire logic [7:0] i_delay,
	output logic o_done,
	output logic [RW-1:0] o_data
);
	int n;

	// Data settle long before done rises; after done the line is released and shows the inverse.
	always @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			n <= 0;
			o_done <= 1'b0;
			o_data <= '0;
		end else if (i_start) begin
			n <= i_delay;
			o_data <= i_value;
		end else if (n > 0) begin
			n <= n - 1;
			o_done <= (n > 1 && n <= 4);
			if (n == 1) o_data <= ~o_data;
		end
	end
endmodule

// ---- adcf_ctrl.sv ----
`timescale 1ns/1ns
`include "adcf_params.svh"
module adcf_ctrl import adcf_pkg::*; #(
	parameter int RESULT_W = 12
) (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_ce,
	input wire logic [5:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_trigger,
	input wire logic i_rc_osc,
	input wire logic i_conv_done,
	input wire logic [RESULT_W-1:0] i_conv_data,
	output adcf_analog_t o_analog,
	output logic o_conv_clock_select,
	output logic o_conv_tick,
	output logic o_irq
);

	typedef struct packed {
		logic [2:0] trig_s;
		logic [2:0] done_s;
		logic [2:0] osc_s;
		logic [RESULT_W-1:0] data_s1;
		logic [RESULT_W-1:0] data_s2;
		logic on;
		logic cont;
		logic cs;
		logic fm;
		logic go;
		logic precharge_polarity;
		logic invert_second_precharge;
		logic guard_polarity;
		logic double_sample_enable;
		adcf_mode_t mode;
		logic [2:0] shift;
		logic soi;
		logic [7:0] rpt;
		logic [7:0] pre_time;
		logic [7:0] div;
		logic [7:0] divcnt;
		logic [7:0] timer;
		logic [7:0] cnt;
		logic [15:0] thresh;
		logic [15:0] acc;
		logic [15:0] lowpass_mode;
		logic [15:0] flt;
		logic [RESULT_W-1:0] res;
		logic [RESULT_W-1:0] prev;
		logic second;
		adcf_state_t st;
		logic [1:0] status;
		logic [1:0] ien;
		logic irq;
		logic waitreq;
		logic [31:0] rdata;
		adcf_analog_t ana;
		logic tick;
	} adcf_ctrl_state_t;

	adcf_ctrl_state_t q;
	adcf_ctrl_state_t next_q;

	logic filt_restart;
	logic [15:0] filt_acc;
	logic [15:0] filt_lpf;
	logic [15:0] filt_out;
	logic avg_mode;

	// A result wider than 15 bits leaves no room for left justification.
	if (RESULT_W < 8 || RESULT_W > 15) begin : g_bad_width
		$error("adcf_ctrl: RESULT_W must lie between 8 and 15");
	end

	// Averaging modes restart the accumulator at the start of each repeat group.
	assign avg_mode = (q.mode == MD_AVG) || (q.mode == MD_BURST);
	assign filt_restart = avg_mode && (q.cnt == 8'h00);

	adcf_filter #(
		.RESULT_W(RESULT_W)
	) u_filter (
		.i_mode(q.mode),
		.i_shift(q.shift),
		.i_restart(filt_restart),
		.i_sample(q.res),
		.i_acc(q.acc),
		.i_lpf(q.lowpass_mode),
		.o_acc(filt_acc),
		.o_lpf(filt_lpf),
		.o_out(filt_out)
	);

	// All next-state logic; configuration writes first, control register 0 after the sequencer, status events last so sets beat clears.
	always_comb begin
		logic trig_edge;
		logic done_edge;
		logic osc_edge;
		logic tick_now;
		logic wr_take;
		logic begin_conv;
		logic nsecond;
		logic inv;
		logic gated;
		logic reached;
		logic thr_hit;
		logic ev_done;
		logic ev_thr;
		logic [1:0] clr_mask;
		logic [7:0] cnt_n;
		logic [15:0] res16;
		logic [15:0] prev16;
		logic [31:0] rmux;
		logic [7:0] wd;
		trig_edge = 1'b0;
		done_edge = 1'b0;
		osc_edge = 1'b0;
		tick_now = 1'b0;
		wr_take = 1'b0;
		begin_conv = 1'b0;
		nsecond = q.second;
		inv = 1'b0;
		gated = 1'b0;
		reached = 1'b0;
		thr_hit = 1'b0;
		ev_done = 1'b0;
		ev_thr = 1'b0;
		clr_mask = 2'h0;
		cnt_n = 8'h00;
		res16 = 16'h0000;
		prev16 = 16'h0000;
		rmux = 32'h0000_0000;
		wd = i_avs_writedata[7:0];
		next_q = q;

		// Pin inputs pass two flip-flops; the third stage only serves edge detection.
		next_q.trig_s = {q.trig_s[1:0], i_trigger};
		next_q.done_s = {q.done_s[1:0], i_conv_done};
		next_q.osc_s = {q.osc_s[1:0], i_rc_osc};
		next_q.data_s1 = i_conv_data;
		next_q.data_s2 = q.data_s1;
		trig_edge = q.trig_s[1] && !q.trig_s[2];
		done_edge = q.done_s[1] && !q.done_s[2];
		osc_edge = q.osc_s[1] && !q.osc_s[2];
		next_q.ana.start = 1'b0;

		// Converter tick from the dedicated oscillator or the divided system clock.
		if (q.cs) begin
			tick_now = osc_edge;
			next_q.divcnt = 8'h00;
		end else if (q.divcnt >= q.div) begin
			tick_now = 1'b1;
			next_q.divcnt = 8'h00;
		end else begin
			next_q.divcnt = q.divcnt + 8'h01;
		end
		next_q.tick = tick_now;

		// Result views, right justified or left justified with zero fill.
		if (q.fm) begin
			res16 = {{(16-RESULT_W){1'b0}}, q.res};
			prev16 = {{(16-RESULT_W){1'b0}}, q.prev};
		end else begin
			res16 = {q.res, {(16-RESULT_W){1'b0}}};
			prev16 = {q.prev, {(16-RESULT_W){1'b0}}};
		end

		// One wait cycle per access; the answer comes in the second cycle of the request.
		next_q.waitreq = !((i_avs_read || i_avs_write) && q.waitreq);
		wr_take = i_avs_write && !q.waitreq && i_avs_byteenable[0];

		// Read decode; unused bits and unmapped offsets read as zero.
		if (i_avs_address == `ADCF_OFF_CTRL0) begin
			rmux[`ADCF_C0_ON] = q.on;
			rmux[`ADCF_C0_CONT] = q.cont;
			rmux[`ADCF_C0_CS] = q.cs;
			rmux[`ADCF_C0_FM] = q.fm;
			rmux[`ADCF_C0_GO] = q.go;
		end else if (i_avs_address == `ADCF_OFF_CTRL1) begin
			rmux[`ADCF_C1_PRECHARGE_POLARITY] = q.precharge_polarity;
			rmux[`ADCF_C1_INVERT_SECOND_PRECHARGE] = q.invert_second_precharge;
			rmux[`ADCF_C1_GUARD_POLARITY] = q.guard_polarity;
			rmux[`ADCF_C1_DOUBLE_SAMPLE_ENABLE] = q.double_sample_enable;
		end else if (i_avs_address == `ADCF_OFF_CTRL2) begin
			rmux[`ADCF_C2_SOI] = q.soi;
			rmux[`ADCF_C2_MODE_LSB +: 3] = q.mode;
			rmux[`ADCF_C2_SHIFT_LSB +: 3] = q.shift;
		end else if (i_avs_address == `ADCF_OFF_RPT) begin
			rmux[7:0] = q.rpt;
		end else if (i_avs_address == `ADCF_OFF_FLTH) begin
			rmux[7:0] = q.flt[15:8];
		end else if (i_avs_address == `ADCF_OFF_FLTL) begin
			rmux[7:0] = q.flt[7:0];
		end else if (i_avs_address == `ADCF_OFF_RESH) begin
			rmux[7:0] = res16[15:8];
		end else if (i_avs_address == `ADCF_OFF_RESL) begin
			rmux[7:0] = res16[7:0];
		end else if (i_avs_address == `ADCF_OFF_PREVH) begin
			rmux[7:0] = prev16[15:8];
		end else if (i_avs_address == `ADCF_OFF_PREVL) begin
			rmux[7:0] = prev16[7:0];
		end else if (i_avs_address == `ADCF_OFF_PRETIME) begin
			rmux[7:0] = q.pre_time;
		end else if (i_avs_address == `ADCF_OFF_THRESH) begin
			rmux[15:0] = q.thresh;
		end else if (i_avs_address == `ADCF_OFF_CLKDIV) begin
			rmux[7:0] = q.div;
		end else if (i_avs_address == `ADCF_OFF_STATUS) begin
			rmux[1:0] = q.status;
		end else if (i_avs_address == `ADCF_OFF_IEN) begin
			rmux[1:0] = q.ien;
		end
		if (i_avs_read && q.waitreq) begin
			next_q.rdata = rmux;
		end

		// Configuration writes; the filter output registers ignore writes.
		if (wr_take) begin
			if (i_avs_address == `ADCF_OFF_CTRL1) begin
				next_q.precharge_polarity = wd[`ADCF_C1_PRECHARGE_POLARITY];
				next_q.invert_second_precharge = wd[`ADCF_C1_INVERT_SECOND_PRECHARGE];
				next_q.guard_polarity = wd[`ADCF_C1_GUARD_POLARITY];
				next_q.double_sample_enable = wd[`ADCF_C1_DOUBLE_SAMPLE_ENABLE];
			end else if (i_avs_address == `ADCF_OFF_CTRL2) begin
				next_q.soi = wd[`ADCF_C2_SOI];
				next_q.mode = adcf_mode_t'(wd[`ADCF_C2_MODE_LSB +: 3]);
				next_q.shift = wd[`ADCF_C2_SHIFT_LSB +: 3];
			end else if (i_avs_address == `ADCF_OFF_RPT) begin
				next_q.rpt = wd;
			end else if (i_avs_address == `ADCF_OFF_PRETIME) begin
				next_q.pre_time = wd;
			end else if (i_avs_address == `ADCF_OFF_THRESH) begin
				next_q.thresh[7:0] = wd;
				if (i_avs_byteenable[1]) begin
					next_q.thresh[15:8] = i_avs_writedata[15:8];
				end
			end else if (i_avs_address == `ADCF_OFF_CLKDIV) begin
				next_q.div = wd;
			end else if (i_avs_address == `ADCF_OFF_CLEAR) begin
				clr_mask = wd[1:0];
			end else if (i_avs_address == `ADCF_OFF_IEN) begin
				next_q.ien = wd[1:0];
			end
		end

		// A trigger pin edge starts a conversion only while enabled.
		if (trig_edge && q.on && !q.go) begin
			next_q.go = 1'b1;
		end

		// Conversion sequencer.
		case (q.st)
			ST_IDLE: begin
				if (q.go && q.on) begin
					nsecond = 1'b0;
					begin_conv = 1'b1;
				end
			end
			ST_PRECHARGE: begin
				if (tick_now) begin
					if (q.timer + 8'h01 >= q.pre_time) begin
						next_q.st = ST_CONVERT;
						next_q.ana.pre_active = 1'b0;
						next_q.ana.pin_to_supply = 1'b0;
						next_q.ana.hold_to_supply = 1'b0;
						next_q.ana.start = 1'b1;
					end else begin
						next_q.timer = q.timer + 8'h01;
					end
				end
			end
			ST_CONVERT: begin
				if (done_edge) begin
					if (q.double_sample_enable && !q.second) begin
						next_q.prev = q.data_s2;
						nsecond = 1'b1;
						begin_conv = 1'b1;
					end else begin
						if (!q.double_sample_enable) begin
							next_q.prev = q.res;
						end
						next_q.res = q.data_s2;
						next_q.st = ST_COMPUTE;
					end
				end
			end
			ST_COMPUTE: begin
				gated = avg_mode || (q.mode == MD_LPF);
				cnt_n = q.cnt + 8'h01;
				reached = !gated || (cnt_n >= q.rpt);
				next_q.cnt = reached ? 8'h00 : cnt_n;
				next_q.acc = filt_acc;
				next_q.lowpass_mode = filt_lpf;
				next_q.flt = filt_out;
				thr_hit = reached && (filt_out > q.thresh);
				ev_done = 1'b1;
				ev_thr = thr_hit;
				if ((q.mode == MD_BURST) && !reached) begin
					nsecond = 1'b0;
					begin_conv = 1'b1;
				end else begin
					next_q.st = ST_IDLE;
					next_q.go = q.cont && !(q.soi && thr_hit);
				end
			end
			default: begin
				next_q.st = ST_IDLE;
			end
		endcase

		// Launch a conversion, with precharge only when a precharge time is set.
		if (begin_conv) begin
			next_q.second = nsecond;
			inv = q.double_sample_enable && q.invert_second_precharge && nsecond;
			if (q.pre_time != 8'h00) begin
				next_q.st = ST_PRECHARGE;
				next_q.timer = 8'h00;
				next_q.ana.pre_active = 1'b1;
				next_q.ana.pin_to_supply = q.precharge_polarity ^ inv;
				next_q.ana.hold_to_supply = !(q.precharge_polarity ^ inv);
			end else begin
				next_q.st = ST_CONVERT;
				next_q.ana.start = 1'b1;
			end
		end

		// Guard level follows its polarity bit, flipped on an inverted second conversion.
		next_q.ana.guard = q.guard_polarity ^ (q.double_sample_enable && q.invert_second_precharge && next_q.second);

		// Control register 0; go set only while enabled, clear while busy aborts.
		if (wr_take && (i_avs_address == `ADCF_OFF_CTRL0)) begin
			next_q.on = wd[`ADCF_C0_ON];
			next_q.cont = wd[`ADCF_C0_CONT];
			next_q.cs = wd[`ADCF_C0_CS];
			next_q.fm = wd[`ADCF_C0_FM];
			if (!wd[`ADCF_C0_ON] || !wd[`ADCF_C0_GO]) begin
				if (q.st != ST_IDLE) begin
					next_q.res = q.data_s2;
				end
				next_q.go = 1'b0;
				next_q.st = ST_IDLE;
				next_q.second = 1'b0;
				next_q.ana = '0;
				next_q.ana.guard = q.guard_polarity;
				ev_done = 1'b0;
				ev_thr = 1'b0;
			end else if (q.on) begin
				next_q.go = 1'b1;
			end
		end

		// Sticky events; a new event wins over a clear in the same cycle.
		next_q.status = (q.status & ~clr_mask) | {ev_thr, ev_done};
		next_q.irq = |(next_q.status & next_q.ien);
	end

	// State register; the clock enable freezes everything, the bus included.
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			q <= '0;
			q.waitreq <= `ADCF_RST_WAITREQ;
		end else if (i_ce) begin
			q <= next_q;
		end
	end

	// Outputs straight from the state register.
	assign o_avs_readdata = q.rdata;
	assign o_avs_waitrequest = q.waitreq;
	assign o_analog = q.ana;
	assign o_conv_clock_select = q.cs;
	assign o_conv_tick = q.tick;
	assign o_irq = q.irq;

endmodule

// ---- adcf_ctrl_asserts.sv ----
`timescale 1ns/1ns
`include "adcf_params.svh"
module adcf_ctrl_asserts import adcf_pkg::*; #(
	parameter int RESULT_W = 12
) (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_ce,
	input wire logic [5:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire logic i_trigger,
	input wire logic i_rc_osc,
	input wire logic i_conv_done,
	input wire logic [RESULT_W-1:0] i_conv_data,
	input wire adcf_analog_t o_analog,
	input wire logic o_conv_clock_select,
	input wire logic o_conv_tick,
	input wire logic o_irq
);
	// One clock domain, so clocking and reset are given once.
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);

	// The bus answers after exactly one wait cycle and only for one cycle.
	property p_wait_one;
		(i_avs_read || i_avs_write) && o_avs_waitrequest && i_ce |=> !o_avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("bus answer not after one wait cycle");
	property p_wait_pulse;
		!o_avs_waitrequest && i_ce |=> o_avs_waitrequest;
	endproperty
	a_wait_pulse: assert property (p_wait_pulse) else $error("bus answer longer than one cycle");
	// Byte registers read back with zero upper lanes.
	property p_read_upper;
		i_avs_read && !o_avs_waitrequest && i_avs_address != `ADCF_OFF_THRESH |-> o_avs_readdata[31:8] == 24'h0;
	endproperty
	a_read_upper: assert property (p_read_upper) else $error("upper read lanes not zero");
	property p_ctrl0_gaps;
		i_avs_read && !o_avs_waitrequest && i_avs_address == `ADCF_OFF_CTRL0 |-> o_avs_readdata[5:5] == 1'b0
			&& o_avs_readdata[3:3] == 1'b0 && o_avs_readdata[1:1] == 1'b0;
	endproperty
	a_ctrl0_gaps: assert property (p_ctrl0_gaps) else $error("unused control bits not zero");
	// Pin and capacitor are tied to opposite rails only while precharging.
	property p_pin_idle;
		!o_analog.pre_active |-> !o_analog.pin_to_supply && !o_analog.hold_to_supply;
	endproperty
	a_pin_idle: assert property (p_pin_idle) else $error("precharge levels outside precharge");
	property p_pin_opp;
		o_analog.pre_active |-> o_analog.pin_to_supply != o_analog.hold_to_supply;
	endproperty
	a_pin_opp: assert property (p_pin_opp) else $error("pin and capacitor on same rail");
	property p_start_once;
		o_analog.start |-> !o_analog.pre_active ##1 !o_analog.start;
	endproperty
	a_start_once: assert property (p_start_once) else $error("start pulse malformed");
	property p_pre_then_start;
		$fell(o_analog.pre_active) |-> ##[0:1] o_analog.start;
	endproperty
	a_pre_then_start: assert property (p_pre_then_start) else $error("no start after precharge");
endmodule

// ---- adcf_filter.sv ----
`timescale 1ns/1ns
module adcf_filter import adcf_pkg::*; #(
	parameter int RESULT_W = 12
) (
	input wire adcf_mode_t i_mode,
	input wire logic [2:0] i_shift,
	input wire logic i_restart,
	input wire logic [RESULT_W-1:0] i_sample,
	input wire logic [15:0] i_acc,
	input wire logic [15:0] i_lpf,
	output logic [15:0] o_acc,
	output logic [15:0] o_lpf,
	output logic [15:0] o_out
);

	logic [15:0] sample16;

	// A wider sample would no longer fit the 16-bit accumulator view.
	if (RESULT_W < 8 || RESULT_W > 15) begin : g_bad_width
		$error("adcf_filter: RESULT_W must lie between 8 and 15");
	end

	assign sample16 = {{(16-RESULT_W){1'b0}}, i_sample};

	// The accumulator wraps on overflow; software picks the shift to keep it in range.
	always_comb begin
		o_acc = (i_restart ? 16'h0000 : i_acc) + sample16;
		o_lpf = i_lpf - (i_lpf >> i_shift) + sample16;
		if (i_mode == MD_LPF) begin
			o_out = o_lpf >> i_shift;
		end else if (i_mode == MD_BASIC) begin
			o_out = sample16;
		end else begin
			o_out = o_acc >> i_shift;
		end
	end

endmodule

// ---- adcf_params.svh ----
`ifndef ADCF_PARAMS_SVH
`define ADCF_PARAMS_SVH

// Register byte offsets on the 32-bit slave port.
`define ADCF_OFF_CTRL0 6'h00
`define ADCF_OFF_CTRL1 6'h04
`define ADCF_OFF_CTRL2 6'h08
`define ADCF_OFF_RPT 6'h0c
`define ADCF_OFF_FLTH 6'h10
`define ADCF_OFF_FLTL 6'h14
`define ADCF_OFF_RESH 6'h18
`define ADCF_OFF_RESL 6'h1c
`define ADCF_OFF_PREVH 6'h20
`define ADCF_OFF_PREVL 6'h24
`define ADCF_OFF_PRETIME 6'h28
`define ADCF_OFF_THRESH 6'h2c
`define ADCF_OFF_CLKDIV 6'h30
`define ADCF_OFF_STATUS 6'h34
`define ADCF_OFF_CLEAR 6'h38
`define ADCF_OFF_IEN 6'h3c

// Field positions of converter_control_0.
`define ADCF_C0_ON 7
`define ADCF_C0_CONT 6
`define ADCF_C0_CS 4
`define ADCF_C0_FM 2
`define ADCF_C0_GO 0

// Field positions of converter_control_1.
`define ADCF_C1_PRECHARGE_POLARITY 7
`define ADCF_C1_INVERT_SECOND_PRECHARGE 6
`define ADCF_C1_GUARD_POLARITY 5
`define ADCF_C1_DOUBLE_SAMPLE_ENABLE 0

// Field positions of converter_control_2.
`define ADCF_C2_SOI 7
`define ADCF_C2_MODE_LSB 4
`define ADCF_C2_SHIFT_LSB 0

// Event bits in status, clear and enable registers.
`define ADCF_EV_DONE 0
`define ADCF_EV_THR 1

// Reset values that are not all zero.
`define ADCF_RST_WAITREQ 1'b1

`endif

// ---- adcf_pkg.sv ----
package adcf_pkg;

	// Computation modes of the filter stage.
	typedef enum logic [2:0] {
		MD_BASIC,
		MD_ACCUM,
		MD_AVG,
		MD_BURST,
		MD_LPF
	} adcf_mode_t;

	// Conversion sequencer states.
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_PRECHARGE,
		ST_CONVERT,
		ST_COMPUTE
	} adcf_state_t;

	// Controls toward the analog sampling stage.
	typedef struct packed {
		logic pre_active;
		logic pin_to_supply;
		logic hold_to_supply;
		logic guard;
		logic start;
	} adcf_analog_t;

endpackage

// ---- tb_top.sv ----
`timescale 1ns/1ns
`include "adcf_params.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_top;
	import adcf_pkg::*;
	localparam int RW = 12;
	logic clk = 0, rst_n = 0, rd = 0, wt = 0, trig = 0, pp, ph, pg, g0, g1, wreq, done, csel, irq;
	logic [5:0] adr = 0;
	logic [31:0] wd = 0, rdata, q, x = 32'd9933;
	logic [3:0] be = 0;
	logic [RW-1:0] cdata, v = 12'h5a5, a;
	logic [7:0] dly = 8'h0c;
	logic [15:0] f;
	adcf_analog_t ana;
	int mismatches = 0, cmp_count = 0, starts = 0, ticks = 0;
	logic osc = 0, tick;
	logic [2:0] oc = 0;
	logic [RW-1:0] vq[$];

	adcf_ctrl #(.RESULT_W(RW)) adcf_ctrl_inst (.i_mclk(clk), .i_resetn(rst_n), .i_ce(1'b1), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wt), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wreq), .i_trigger(trig), .i_rc_osc(osc), .i_conv_done(done), .i_conv_data(cdata),
		.o_analog(ana), .o_conv_clock_select(csel), .o_conv_tick(tick), .o_irq(irq));
	adcf_analog_model #(.RW(RW)) adcf_analog_model_inst (.i_mclk(clk), .i_resetn(rst_n), .i_start(ana.start),
		.i_value(v), .i_delay(dly), .o_done(done), .o_data(cdata));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	// The clock inverts every 10 ns, half its period of 20 ns.
	initial begin
		forever #10 clk = ~clk;
	end

	// A free-running oscillator pin with one rising edge every eight clocks.
	always @(posedge clk) begin
		oc <= oc + 3'h1;
		osc <= oc[2];
	end

	// Records each sample handed out and the levels seen in the first precharge.
	always @(posedge clk) begin
		if (ana.start) begin
			starts <= starts + 1;
			vq.push_back(v);
			x = xs(x);
			v <= x[RW-1:0] | 12'h001;
			if (starts == 0) g0 <= ana.guard;
			else g1 <= ana.guard;
		end
		if (ana.pre_active && starts == 0) begin
			pp <= ana.pin_to_supply;
			ph <= ana.hold_to_supply;
			pg <= ana.guard;
		end
	end

	// Holds each request until waitrequest is sampled low.
	task automatic bus(input logic w, input logic [5:0] ad, input logic [15:0] d);
		adr <= ad;
		wd <= {16'h0, d};
		be <= 4'h3;
		rd <= !w;
		wt <= w;
		@(posedge clk);
		while (wreq !== 1'b0) begin
			@(posedge clk);
		end
		q = rdata;
		rd <= 1'b0;
		wt <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rchk(input logic [5:0] ad, input logic [7:0] e, input string n);
		bus(1'b0, ad, 16'h0);
		`CHK(n, {24'h0, e}, q)
	endtask

	// Clears events, starts one trigger by go or by the pin, and polls until done.
	task automatic conv(input logic [7:0] c0, input logic pin);
		int n;
		n = 0;
		bus(1'b1, `ADCF_OFF_CLEAR, 16'h3);
		vq.delete();
		starts = 0;
		bus(1'b1, `ADCF_OFF_CTRL0, {8'h0, c0});
		if (pin) trig <= 1'b1;
		else bus(1'b1, `ADCF_OFF_CTRL0, {8'h0, c0 | 8'h01});
		do begin
			bus(1'b0, `ADCF_OFF_STATUS, 16'h0);
			n++;
		end while (q[0] !== 1'b1 && n < 100);
		`CHK("done", 1'b1, q[0])
		trig <= 1'b0;
	endtask

	task automatic results;
		$display("counts mismatches=%0d comparisons=%0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// A hang is cut off well beyond the expected run length.
	initial begin
		#(20 * 60000);
		mismatches++;
		results;
	end

	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 6; i++) rchk(6'(i * 4), 8'h00, "reset");
		bus(1'b1, `ADCF_OFF_CTRL1, 16'hff);
		rchk(`ADCF_OFF_CTRL1, 8'he1, "ctrl1");
		bus(1'b1, `ADCF_OFF_CTRL0, 16'h3f);
		rchk(`ADCF_OFF_CTRL0, 8'h14, "ctrl0");
		`CHK("csel", 1'b1, csel)
		bus(1'b1, `ADCF_OFF_FLTH, 16'hff);
		rchk(`ADCF_OFF_FLTH, 8'h00, "flth");
		$display("test registers done");
		// Low-pass first, while its state is still clear; one trigger per check.
		bus(1'b1, `ADCF_OFF_CTRL1, 16'h0);
		bus(1'b1, `ADCF_OFF_CTRL2, 16'h42);
		bus(1'b1, `ADCF_OFF_RPT, 16'h1);
		bus(1'b1, `ADCF_OFF_IEN, 16'h1);
		conv(8'h84, 1'b0);
		`CHK("thr", 1'b1, q[1])
		`CHK("irq", 1'b1, irq)
		f = 16'(vq[0]) >> 2;
		rchk(`ADCF_OFF_FLTH, f[15:8], "flth");
		rchk(`ADCF_OFF_FLTL, f[7:0], "fltl");
		$display("test lowpass done");
		// Average of two triggers, threshold only after the second.
		bus(1'b1, `ADCF_OFF_CTRL2, 16'h21);
		bus(1'b1, `ADCF_OFF_RPT, 16'h2);
		conv(8'h84, 1'b0);
		a = vq[0];
		`CHK("thr", 1'b0, q[1])
		conv(8'h84, 1'b0);
		`CHK("thr", 1'b1, q[1])
		f = (16'(a) + 16'(vq[0])) >> 1;
		rchk(`ADCF_OFF_FLTH, f[15:8], "flth");
		rchk(`ADCF_OFF_FLTL, f[7:0], "fltl");
		$display("test average done");
		// Basic mode with the event masked, both justifications, pin trigger.
		bus(1'b1, `ADCF_OFF_CTRL2, 16'h0);
		bus(1'b1, `ADCF_OFF_IEN, 16'h0);
		conv(8'h80, 1'b1);
		`CHK("irq", 1'b0, irq)
		`CHK("starts", 1, starts)
		rchk(`ADCF_OFF_RESH, vq[0][11:4], "resh");
		rchk(`ADCF_OFF_RESL, {vq[0][3:0], 4'h0}, "resl");
		conv(8'h84, 1'b0);
		rchk(`ADCF_OFF_RESH, {4'h0, vq[0][11:8]}, "resh");
		$display("test basic done");
		// Every polarity combination with double sampling and precharge.
		bus(1'b1, `ADCF_OFF_PRETIME, 16'h2);
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, `ADCF_OFF_CTRL1, {8'h0, 3'(i), 5'h01});
			conv(8'h84, 1'b0);
			`CHK("starts", 2, starts)
			`CHK("pin", i[2], pp)
			`CHK("hold", !i[2], ph)
			`CHK("gpre", i[0], pg)
			`CHK("g0", i[0], g0)
			`CHK("g1", i[0] ^ i[1], g1)
			rchk(`ADCF_OFF_PREVL, vq[0][7:0], "prev");
			rchk(`ADCF_OFF_RESL, vq[1][7:0], "res");
		end
		$display("test double sample done");
		// Burst of two conversions on one trigger; the threshold is only checked after the second.
		bus(1'b1, `ADCF_OFF_CTRL1, 16'h0);
		bus(1'b1, `ADCF_OFF_CTRL2, 16'h30);
		bus(1'b1, `ADCF_OFF_RPT, 16'h2);
		conv(8'h84, 1'b0);
		repeat (60) @(posedge clk);
		f = 16'(vq[0]) + 16'(vq[1]);
		`CHK("starts", 2, starts)
		rchk(`ADCF_OFF_STATUS, 8'h03, "status");
		rchk(`ADCF_OFF_FLTL, f[7:0], "fltl");
		rchk(`ADCF_OFF_FLTH, f[15:8], "flth");
		$display("test burst done");
		// Continuous accumulate keeps the old sum and stops itself once the threshold is passed.
		bus(1'b1, `ADCF_OFF_CTRL2, 16'h90);
		conv(8'hc4, 1'b0);
		repeat (60) @(posedge clk);
		f = f + 16'(vq[0]);
		`CHK("starts", 1, starts)
		rchk(`ADCF_OFF_CTRL0, 8'hc4, "cont");
		rchk(`ADCF_OFF_FLTL, f[7:0], "acc");
		rchk(`ADCF_OFF_FLTH, f[15:8], "acch");
		$display("test continuous done");
		// Abort mid-conversion; the late done edge must be ignored.
		bus(1'b1, `ADCF_OFF_CTRL1, 16'h0);
		dly <= 8'h3c;
		vq.delete();
		bus(1'b1, `ADCF_OFF_CLEAR, 16'h3);
		bus(1'b1, `ADCF_OFF_CTRL0, 16'h85);
		repeat (10) @(posedge clk);
		bus(1'b1, `ADCF_OFF_CTRL0, 16'h84);
		repeat (70) @(posedge clk);
		rchk(`ADCF_OFF_STATUS, 8'h00, "status");
		rchk(`ADCF_OFF_RESL, vq[0][7:0], "partial");
		rchk(`ADCF_OFF_CTRL0, 8'h84, "go");
		$display("test abort done");
		// Converter ticks from the divided clock, then from the oscillator pin.
		bus(1'b1, `ADCF_OFF_CLKDIV, 16'h3);
		ticks = 0;
		repeat (40) begin
			@(posedge clk);
			if (tick === 1'b1) ticks++;
		end
		`CHK("divticks", 10, ticks)
		bus(1'b1, `ADCF_OFF_CTRL0, 16'h10);
		ticks = 0;
		repeat (80) begin
			@(posedge clk);
			if (tick === 1'b1) ticks++;
		end
		`CHK("oscticks", 10, ticks)
		$display("test clock select done");
		results;
	end
endmodule

bind adcf_ctrl adcf_ctrl_asserts #(.RESULT_W(RESULT_W)) adcf_ctrl_asserts_inst (.i_mclk(i_mclk),
	.i_resetn(i_resetn), .i_ce(i_ce), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
	.i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
	.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_trigger(i_trigger),
	.i_rc_osc(i_rc_osc), .i_conv_done(i_conv_done), .i_conv_data(i_conv_data), .o_analog(o_analog),
	.o_conv_clock_select(o_conv_clock_select), .o_conv_tick(o_conv_tick), .o_irq(o_irq));
